/* File: dv/mpmp_mem_model.sv */
/*
 partner model: external address latch plus a small memory.
 assumes it sees the port's pin levels directly; no pin timing modelled.
*/
`timescale 1ns/1ps
module mpmp_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_ale,
    input  wire logic        i_ale_act_low,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic [15:0] i_ad,
    output logic      [15:0] o_ad,
    output logic      [15:0] o_latch
);
    // ------------------------------------------------------------
    // latch and storage
    // ------------------------------------------------------------
    logic [15:0] mem [logic [15:0]];
    initial o_latch = 16'h0000;
    always @(posedge i_clk) begin
        if ((i_ale ^ i_ale_act_low) === 1'b1) o_latch <= i_ad;
        if (i_wr_n === 1'b0) mem[o_latch] = i_ad;
    end
    // released bus sits at the pull-up level, never at the last value
    always @* begin
        if (i_rd_n === 1'b0) begin
            o_ad = mem.exists(o_latch) ? mem[o_latch] : o_latch ^ 16'ha5c3;
        end else begin
            o_ad = 16'hffff;
        end
    end
endmodule : mpmp_mem_model

/* File: dv/mpmp_port_bench.sv */
/*
 self-checking bench for the muxed port, random and corner accesses.
 assumes the default strobe length and the memory model on the pins.
*/
`timescale 1ns/1ps
module mpmp_port_bench;
    import mpmp_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic              clk = 0, rst = 1, flag = 0, alow = 0, w16 = 1, req = 0, wr = 0;
    logic              ce = 1;
    logic [ADDR_W-1:0] addr = '0, a;
    logic [AD_W-1:0]   wdata = '0, ad_in, rdata, ad_out, latch, d;
    logic              busy, done, oe_n, ale, rd_n, wr_n, up_ok = 0;
    logic [15:0]       last_up = '0;
    logic [15:0]       refm [logic [15:0]];
    int                mismatches = 0, check_count = 0;
    always #10 clk = ~clk;
    mpmp_port i_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_CE(ce), .I_FLAG_MODE(flag),
        .I_ALE_ACT_LOW(alow), .I_WIDTH16(w16), .I_REQ(req), .I_WRITE(wr), .I_ADDR(addr),
        .I_WDATA(wdata), .I_AD_IN(ad_in), .O_BUSY(busy), .O_DONE(done), .O_RDATA(rdata),
        .O_AD_OUT(ad_out), .O_AD_OE_N(oe_n), .O_ALE(ale), .O_RD_N(rd_n), .O_WR_N(wr_n));
    mpmp_mem_model i_mem (.i_clk(clk), .i_ale(ale), .i_ale_act_low(alow), .i_rd_n(rd_n),
        .i_wr_n(wr_n), .i_ad(ad_out), .o_ad(ad_in), .o_latch(latch));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check
    function automatic logic [15:0] exp_val(input logic [15:0] k);
        return refm.exists(k) ? refm[k] : k ^ 16'ha5c3;
    endfunction : exp_val
    // bounded wait for the done pulse; a hang ends the run
    task automatic wait_done();
        int n;
        for (n = 0; n < 20 && done !== 1'b1; n++) @(negedge clk);
        if (n == 20) begin
            mismatches++;
            $display("[ERR] %0t done timeout", $time);
            results();
        end
    endtask : wait_done
    // one access from idle; counts strobe cycles up to the done pulse
    task automatic access(input logic w, m16, input logic [23:0] ad, input logic [15:0] dt,
                          input int exp_ale);
        int          k, n_ale, n_rd, n_wr;
        logic [15:0] wd;
        n_ale = 0; n_rd = 0; n_wr = 0;
        wd = '0;
        wr = w; w16 = m16; addr = ad; wdata = dt; req = 1;
        @(negedge clk);
        req = 0;
        for (k = 0; k < 20 && done !== 1'b1; k++) begin
            if ((ale ^ alow) === 1'b1) begin
                n_ale++;
                check(oe_n === 1'b0 && ad_out === (m16 ? ad[15:0] : ad[23:8]), "addr phase");
            end
            if (rd_n === 1'b0) check(oe_n === 1'b1, "bus released in read");
            if (wr_n === 1'b0) wd = ad_out;
            n_rd += (rd_n === 1'b0);
            n_wr += (wr_n === 1'b0);
            @(negedge clk);
        end
        if (k == 20) begin
            mismatches++;
            $display("[ERR] %0t access timeout", $time);
            results();
        end
        check(n_ale == exp_ale, "latch strobe count");
        check(n_rd == (w ? 0 : STRB_CYC), "read strobe length");
        check(n_wr == (w ? STRB_CYC : 0), "write strobe length");
        if (w) check(wd === (m16 ? dt : {8'h00, dt[7:0]}), "write data on pins");
        @(negedge clk);
    endtask : access
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(82));
        repeat (20) @(negedge clk);
        rst = 0;
        check(oe_n === 1'b1 && rd_n === 1'b1 && wr_n === 1'b1 && ale === 1'b0, "reset");
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? '0 : (i == 1) ? '1 : 24'($urandom);
            d = 16'($urandom);
            access(1'b1, 1'b1, a, d, 1);
            refm[a[15:0]] = d;
            access(1'b0, 1'b1, a, 16'h0000, 1);
            check(rdata === d, "16-bit read data");
        end
        $display("16-bit test done");
        for (int i = 0; i < 12; i++) begin
            a = (i % 3 == 1) ? {last_up, 8'($urandom)} : 24'($urandom);
            d = 16'($urandom);
            access(i >= 10, 1'b0, a, d, (!up_ok || a[23:8] != last_up) ? 1 : 0);
            if (i >= 10) begin
                refm[a[23:8]] = {8'h00, d[7:0]};
            end else begin
                d = exp_val(a[23:8]);
                check(rdata === {8'h00, d[7:0]}, "8-bit read");
            end
            up_ok = 1;
            last_up = a[23:8];
        end
        // same upper bits as the last write, so no latch strobe
        access(1'b0, 1'b0, a, 16'h0000, 0);
        check(rdata === exp_val(a[23:8]), "8-bit write read back");
        $display("8-bit test done");
        flag = 1;
        req = 1;
        repeat (10) begin
            @(negedge clk);
            check(busy === 1'b0 && rd_n === 1'b1 && wr_n === 1'b1 && ale === 1'b0, "flags");
        end
        flag = 0;
        req = 0;
        $display("flag test done");
        alow = 1;
        @(negedge clk);
        check(ale === 1'b1, "low-active strobe idle");
        access(1'b1, 1'b1, 24'h12abcd, 16'h5aa5, 1);
        alow = 0;
        $display("polarity test done");
        // enable held low mid-write freezes pins and state
        wr = 1;
        addr = 24'h00c0de;
        wdata = 16'h1234;
        req = 1;
        @(negedge clk);
        req = 0;
        @(negedge clk);
        ce = 0;
        repeat (4) begin
            @(negedge clk);
            check(busy && !wr_n && ad_out === 16'h1234, "enable freeze");
        end
        ce = 1;
        wait_done();
        check(wr_n && oe_n && !busy, "resume after freeze");
        @(negedge clk);
        $display("enable test done");
        // reset in mid-read drops the strobes and releases the bus
        wr = 0;
        req = 1;
        @(negedge clk);
        req = 0;
        @(negedge clk);
        check(!rd_n && oe_n, "read under way");
        rst = 1;
        repeat (2) @(negedge clk);
        check(!busy && oe_n && rd_n && !ale, "mid-run reset");
        rst = 0;
        repeat (3) begin
            @(negedge clk);
            check(oe_n && rd_n && wr_n && !done, "idle after reset");
        end
        $display("reset test done");
        results();
    end
endmodule : mpmp_port_bench

/* File: rtl/mpmp_port.sv */
/*
 muxed parallel memory port top: one access at a time over a 16-pin
 address/data bus with address latch strobe and read/write strobes.
 assumes an external latch on the strobe and synchronous memory inputs.
*/
// Behaviour
// - sixteen pins carry address or data; latch strobe marks address phases
// - 8-bit or 16-bit transfer width chosen by configuration
// - 8-bit mode pulses latch strobe when upper 16 address bits change
// - read strobe low during every read, high otherwise
// - write strobe low during every write, high otherwise
// - flag mode keeps read and write strobes inactive
// - latch strobe active high after reset, polarity programmable, idle in flag mode
`timescale 1ns/1ps
module mpmp_port
    import mpmp_pkg::*;
#(
    parameter int STRB_CYCLES = STRB_CYC
)(
    input  wire logic              I_CLK,
    input  wire logic              I_SYS_RST,
    input  wire logic              I_CE,
    input  wire logic              I_FLAG_MODE,
    input  wire logic              I_ALE_ACT_LOW,
    input  wire logic              I_WIDTH16,
    input  wire logic              I_REQ,
    input  wire logic              I_WRITE,
    input  wire logic [ADDR_W-1:0] I_ADDR,
    input  wire logic [AD_W-1:0]   I_WDATA,
    input  wire logic [AD_W-1:0]   I_AD_IN,
    output logic                   O_BUSY,
    output logic                   O_DONE,
    output logic [AD_W-1:0]        O_RDATA,
    output logic [AD_W-1:0]        O_AD_OUT,
    output logic                   O_AD_OE_N,
    output logic                   O_ALE,
    output logic                   O_RD_N,
    output logic                   O_WR_N
);
    mpmp_state_type    st_q, st_d;
    logic [3:0]        cnt_q, cnt_d;
    logic              wr_q, wr_d, oe_n_q, oe_n_d, done_q, done_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [AD_W-1:0]   dat_q, dat_d, ad_q, ad_d, rdat_q, rdat_d;
    logic [UP_W-1:0]   up_q, up_d;
    logic              up_vld_q, up_vld_d;
    logic              ale_ph, rd_ph, wr_ph;

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    always_comb begin
        st_d     = st_q;
        cnt_d    = cnt_q;
        wr_d     = wr_q;
        addr_d   = addr_q;
        dat_d    = dat_q;
        ad_d     = ad_q;
        oe_n_d   = oe_n_q;
        rdat_d   = rdat_q;
        done_d   = 1'b0;
        up_d     = up_q;
        up_vld_d = up_vld_q;
        case (st_q)
            ST_IDLE: begin
                oe_n_d = 1'b1;
                if (I_REQ && !I_FLAG_MODE) begin
                    wr_d   = I_WRITE;
                    addr_d = I_ADDR;
                    dat_d  = I_WDATA;
                    // 8-bit mode skips the address phase if upper bits unchanged
                    if (!I_WIDTH16 && up_vld_q && I_ADDR[UP_LSB +: UP_W] == up_q) begin
                        st_d   = ST_STRB;
                        cnt_d  = 4'(STRB_CYCLES);
                        ad_d   = {8'h00, I_ADDR[UP_LSB-1:0]};
                        // a read leaves the pins to the memory while its strobe is low
                        oe_n_d = !I_WRITE;
                    end else begin
                        st_d   = ST_ADDR;
                        cnt_d  = 4'(ALE_CYC);
                        ad_d   = I_WIDTH16 ? I_ADDR[AD_W-1:0] : I_ADDR[UP_LSB +: UP_W];
                        oe_n_d = 1'b0;
                    end
                end
            end
            ST_ADDR: begin
                if (cnt_q == CNT_ONE) begin
                    st_d     = ST_STRB;
                    cnt_d    = 4'(STRB_CYCLES);
                    up_d     = addr_q[UP_LSB +: UP_W];
                    up_vld_d = !I_WIDTH16;
                    // 8-bit writes show the low address byte first; a read releases the pins
                    ad_d     = (wr_q && I_WIDTH16) ? dat_q : {8'h00, addr_q[UP_LSB-1:0]};
                    oe_n_d   = !wr_q;
                end else begin
                    cnt_d = cnt_q - CNT_ONE;
                end
            end
            ST_STRB: begin
                if (wr_q) begin
                    ad_d   = I_WIDTH16 ? dat_q : {8'h00, dat_q[7:0]};
                    oe_n_d = 1'b0;
                end else begin
                    oe_n_d = 1'b1;
                end
                if (cnt_q == CNT_ONE) begin
                    st_d = ST_HOLD;
                    if (!wr_q) begin
                        rdat_d = I_WIDTH16 ? I_AD_IN : {8'h00, I_AD_IN[7:0]};
                    end
                end else begin
                    cnt_d = cnt_q - CNT_ONE;
                end
            end
            ST_HOLD: begin
                st_d   = ST_DONE;
                oe_n_d = 1'b1;
            end
            ST_DONE: begin
                st_d   = ST_IDLE;
                done_d = 1'b1;
            end
            default: begin
                st_d   = ST_IDLE;
                oe_n_d = 1'b1;
            end
        endcase
        // flag mode drops the remembered upper address, forcing a new latch
        if (I_FLAG_MODE) begin
            up_vld_d = 1'b0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            st_q     <= ST_IDLE;
            cnt_q    <= 4'h0;
            wr_q     <= 1'b0;
            addr_q   <= '0;
            dat_q    <= '0;
            ad_q     <= '0;
            oe_n_q   <= 1'b1;
            rdat_q   <= '0;
            done_q   <= 1'b0;
            up_q     <= UP_RST;
            up_vld_q <= 1'b0;
        end else if (I_CE) begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            wr_q     <= wr_d;
            addr_q   <= addr_d;
            dat_q    <= dat_d;
            ad_q     <= ad_d;
            oe_n_q   <= oe_n_d;
            rdat_q   <= rdat_d;
            done_q   <= done_d;
            up_q     <= up_d;
            up_vld_q <= up_vld_d;
        end
    end

    // --------------------------------------------------------------
    // phases to pins
    // --------------------------------------------------------------
    assign ale_ph = (st_d == ST_ADDR);
    assign rd_ph  = (st_d == ST_STRB) && !wr_d;
    assign wr_ph  = (st_d == ST_STRB) && wr_d;

    mpmp_strobe_gen u_strobe (
        .i_clk       (I_CLK),
        .i_rst       (I_SYS_RST),
        .i_ce        (I_CE),
        .i_flag_mode (I_FLAG_MODE),
        .i_ale_pol   (!I_ALE_ACT_LOW),
        .i_ale_phase (ale_ph),
        .i_rd_phase  (rd_ph),
        .i_wr_phase  (wr_ph),
        .o_ale       (O_ALE),
        .o_rd_n      (O_RD_N),
        .o_wr_n      (O_WR_N)
    );

    assign O_BUSY    = (st_q != ST_IDLE);
    assign O_DONE    = done_q;
    assign O_RDATA   = rdat_q;
    assign O_AD_OUT  = ad_q;
    assign O_AD_OE_N = oe_n_q;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    // strobes are registered from the next state, so they match st_q at the same edge
    AST_RST_IDLE: assert property (@(posedge I_CLK)
        ($past(I_SYS_RST) && !I_SYS_RST) |-> (O_AD_OE_N && O_RD_N && O_WR_N))
        else $error("pins not idle after reset");
    AST_RD_PULSE: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        ($past(I_CE) && !$past(I_FLAG_MODE) && st_q == ST_STRB && !wr_q) |-> !O_RD_N)
        else $error("read strobe not low in read");
    AST_WR_PULSE: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        ($past(I_CE) && !$past(I_FLAG_MODE) && st_q == ST_STRB && wr_q) |-> !O_WR_N)
        else $error("write strobe not low in write");
    AST_NO_BOTH: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !(!O_RD_N && !O_WR_N))
        else $error("read and write both active");
    AST_IDLE_HIGH: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (st_q == ST_IDLE && $past(st_q) == ST_IDLE) |-> (O_RD_N && O_WR_N))
        else $error("strobe active while idle");
    AST_UP_CHANGE: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_CE && st_q == ST_IDLE && I_REQ && !I_FLAG_MODE && !I_WIDTH16
         && I_ADDR[UP_LSB +: UP_W] != up_q) |=> st_q == ST_ADDR)
        else $error("upper address change without latch phase");
    AST_ALE_POL: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_CE && st_q == ST_ADDR && !I_FLAG_MODE && !I_ALE_ACT_LOW
         && $past(I_CE) && !$past(I_ALE_ACT_LOW)) |-> O_ALE)
        else $error("latch strobe not high in address phase");
    AST_ADDR_ON_BUS: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (st_q == ST_ADDR) |-> !O_AD_OE_N)
        else $error("address phase with bus released");
    AST_RD_RELEASED: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !O_RD_N |-> O_AD_OE_N)
        else $error("bus driven while memory reads");
    AST_FLAG_NO_TAKE: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_CE && st_q == ST_IDLE && I_FLAG_MODE) |=> st_q == ST_IDLE)
        else $error("access taken in flag mode");
endmodule : mpmp_port

/* File: rtl/mpmp_strobe_gen.sv */
/*
 strobe generator: turns the sequencer phase into the read, write and
 address-latch pin levels. assumes phase inputs are decoded unregistered from the next state.
*/
`timescale 1ns/1ps
module mpmp_strobe_gen
    import mpmp_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    input  wire logic i_flag_mode,
    input  wire logic i_ale_pol,
    input  wire logic i_ale_phase,
    input  wire logic i_rd_phase,
    input  wire logic i_wr_phase,
    output logic      o_ale,
    output logic      o_rd_n,
    output logic      o_wr_n
);
    logic ale_q, ale_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d;

    // --------------------------------------------------------------
    // next pin levels
    // --------------------------------------------------------------
    always_comb begin
        ale_d  = i_flag_mode ? ~i_ale_pol : (i_ale_phase ? i_ale_pol : ~i_ale_pol);
        rd_n_d = ~(i_rd_phase && !i_flag_mode);
        wr_n_d = ~(i_wr_phase && !i_flag_mode);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ale_q  <= ALE_POL_RST ? 1'b0 : 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else if (i_ce) begin
            ale_q  <= ale_d;
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
        end
    end

    assign o_ale  = ale_q;
    assign o_rd_n = rd_n_q;
    assign o_wr_n = wr_n_q;

    AST_FLAG_IDLE: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_flag_mode && i_ce) |=> (rd_n_q && wr_n_q && ale_q == ~$past(i_ale_pol)))
        else $error("strobes active in flag mode");
endmodule : mpmp_strobe_gen

/* File: shared/mpmp_pkg.sv */
/*
 muxed parallel memory port: shared constants, state encoding.
 assumes a single 50 MHz system clock and synchronous active-high reset.
*/
package mpmp_pkg;
    // --------------------------------------------------------------
    // widths and timing
    // --------------------------------------------------------------
    localparam int AD_W         = 16;
    localparam int ADDR_W       = 24;
    localparam int UP_LSB       = 8;
    localparam int UP_W         = 16;
    localparam int CLK_NS       = 20;
    localparam int STRB_NS      = 40;
    localparam int STRB_CYC     = (STRB_NS + CLK_NS - 1) / CLK_NS;
    localparam int ALE_CYC      = 1;
    localparam logic [15:0] UP_RST = 16'hffff;
    localparam logic        ALE_POL_RST = 1'b1;
    localparam logic [3:0]  CNT_ONE = 4'h1;

    // --------------------------------------------------------------
    // port sequencer states
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_STRB  = 3'b010,
        ST_HOLD  = 3'b011,
        ST_DONE  = 3'b100
    } mpmp_state_type;
endpackage : mpmp_pkg
